// [shared/dps_consts.vh]
// Constants for the drive protection supervisor: register offsets,
// reset values, setting ranges and time bases.
// Assumes a 100 MHz ref_clk and 0.1 % scaled current and voltage samples.
`ifndef DPS_CONSTS_VH
`define DPS_CONSTS_VH
// Time base
`define DPS_CLK_NS       10
`define DPS_MS_NS        1000000
`define DPS_DS_PER_MS    7'h63
`define DPS_MINUTE_DS    10'h258
`define DPS_KEY_GAP_DS   10'h014
// Register byte offsets
`define DPS_OFF_CTRL     8'h00
`define DPS_OFF_PREALM   8'h04
`define DPS_OFF_LIMIT    8'h08
`define DPS_OFF_STALL    8'h0C
`define DPS_OFF_PHASE    8'h10
`define DPS_OFF_RETRY    8'h14
`define DPS_OFF_STATUS   8'h18
`define DPS_OFF_FCLR     8'h1C
// Reset values
`define DPS_CTRL_RST     6'h05
`define DPS_PA_LVL_RST   16'h0640
`define DPS_PA_TIM_RST   16'h0258
`define DPS_LIM_HD_RST   16'h00A0
`define DPS_LIM_LD_RST   16'h0078
`define DPS_CONF_RST     16'h0032
`define DPS_STALL_HI_RST 16'h0578
`define DPS_STALL_LO_RST 16'h04B0
`define DPS_INB_RST      16'h0064
`define DPS_INT_RST      16'h000A
`define DPS_OUTB_RST     16'h0001
`define DPS_OUTT_RST     16'h0014
`define DPS_RCNT_RST     16'h0000
`define DPS_RINT_RST     16'h0032
// Setting ranges
`define DPS_PA_LVL_MIN   16'h00C8
`define DPS_PA_LVL_MAX   16'h07D0
`define DPS_PA_TIM_MAX   16'h0258
`define DPS_LIM_HD_MIN   16'h001E
`define DPS_LIM_HD_MAX   16'h00B4
`define DPS_LIM_LD_MIN   16'h003C
`define DPS_LIM_LD_MAX   16'h008C
`define DPS_CONF_MAX     16'h00C8
`define DPS_STALL_MIN    16'h044C
`define DPS_STALL_MAX    16'h05DC
`define DPS_PCT_MAX      16'h0064
`define DPS_INT_MIN      16'h0002
`define DPS_INT_MAX      16'h00FF
`define DPS_OUTT_MAX     16'h00C8
`define DPS_RCNT_MAX     16'h000A
`define DPS_RINT_MIN     16'h0014
`define DPS_RINT_MAX     16'h00C8
// Fixed hardware limit, 230.0 %
`define DPS_HW_LIMIT     12'h8FC
// Fault vector bits
`define DPS_F_MOL        0
`define DPS_F_IOL        1
`define DPS_F_OV         2
`define DPS_F_OC         3
`define DPS_F_GF         4
`define DPS_F_INPH       5
`define DPS_F_OUTPH      6
`define DPS_F_SHORT      7
`define DPS_AUTO_MASK    8'h1C
`endif

// [src/dps_supervisor.v]
// Drive protection supervisor: thresholds, timers, faults, retry, run guard.
// Assumes synchronous sensing inputs, APB register access, 100 MHz clock.
// Overview of operation
// - Thermal trip blocks output, reports motor overload
// - Pre-alarm level 20.0 to 200.0, default 160.0
// - Pre-alarm after continuous overcurrent for detect time
// - Current dropping below threshold clears pre-alarm timer
// - Limit mode 0 off,1 ramps,2 always,3 reduce
// - Limit level range depends on duty rating
// - Modes 1,2 freeze frequency while limiting on ramps
// - Mode 2 constant speed limiting lowers frequency
// - Mode 3 reduces after confirm time elapses
// - Decel limiting over one minute: inverter overload
// - Two stop presses two seconds apart: overload while decel limiting, over-voltage while stalling
// - Over-voltage during decel holds frequency when enabled
// - Stall point 110.0 to 150.0, rating default
// - Stall over one minute reports over-voltage, coast
// - Input phase loss by benchmark and seconds
// - Output phase loss by benchmark and tenths
// - Analog alarms shown only when enabled
// - Only OC, OV, ground faults auto reset
// - Output blocked during retry, then restart
// - Power-up guard reads ctrl bit 4 at its reset value 0, so a power-up run command is never ignored
// - Source change needs fresh run command
// - Hardware limit fixed at 230.0 percent
`timescale 1ns/1ps
`include "dps_consts.vh"
module dps_supervisor #(
	parameter MS_CYCLES  = `DPS_MS_NS / `DPS_CLK_NS,
	parameter HEAVY_DUTY = 1,
	parameter V380       = 1
) (
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        sample_valid,
	input  wire [11:0] out_current,
	input  wire [10:0] bus_voltage,
	input  wire [6:0]  in_imbalance,
	input  wire [6:0]  out_imbalance,
	input  wire        accel,
	input  wire        decel,
	input  wire        thermal_trip,
	input  wire        oc_event,
	input  wire        gf_event,
	input  wire        short_event,
	input  wire        analog_one_bad,
	input  wire        analog_two_bad,
	input  wire        stop_key,
	input  wire        run_cmd,
	input  wire        source_change,
	output reg         pwm_block,
	output reg         coast_stop,
	output reg         freq_hold,
	output reg         freq_reduce,
	output reg         hw_limit,
	output reg         overload_prealarm_flag,
	output reg         analog_one_alarm,
	output reg         analog_two_alarm,
	output reg  [7:0]  fault_flags,
	output reg         run_enable,
	output reg         decel_to_stop,
	output reg         restart_pulse
);
	// Clamp a written setting into its legal range
	function [15:0] clampv;
		input [15:0] v;
		input [15:0] lo;
		input [15:0] hi;
		begin
			clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
		end
	endfunction

	wire [31:0] ms_last_w = MS_CYCLES - 1;     // Truncated below
	wire [15:0] lim_min = HEAVY_DUTY ? `DPS_LIM_HD_MIN : `DPS_LIM_LD_MIN;
	wire [15:0] lim_max = HEAVY_DUTY ? `DPS_LIM_HD_MAX : `DPS_LIM_LD_MAX;
	reg  [5:0]  ctrl_q;       // Mode, stall en, analog en, guards
	reg  [15:0] pa_lvl_q;     // Pre-alarm level, 0.1 %
	reg  [15:0] pa_tim_q;     // Pre-alarm time, 0.1 s
	reg  [15:0] lim_lvl_q;    // Limit level, 1 %
	reg  [15:0] conf_q;       // Confirm time, ms
	reg  [15:0] stall_q;      // Stall point, 0.1 %
	reg  [15:0] inb_q;        // Input phase benchmark, %
	reg  [15:0] int_q;        // Input phase time, s
	reg  [15:0] outb_q;       // Output phase benchmark, %
	reg  [15:0] outt_q;       // Output phase time, 0.1 s
	reg  [15:0] rcnt_q;       // Retry count
	reg  [15:0] rint_q;       // Retry interval, 0.1 s
	reg  [11:0] cur_q;        // Latched current sample
	reg  [10:0] bus_q;        // Latched bus voltage sample
	reg  [16:0] ms_cnt_q;     // Cycle divider to 1 ms
	reg  [6:0]  ds_cnt_q;     // ms divider to 100 ms
	reg         tick_ms_q;
	reg         tick_ds_q;
	reg  [15:0] pa_cnt_q;     // Pre-alarm persistence
	reg  [15:0] conf_cnt_q;   // Mode 3 confirm, ms
	reg  [9:0]  dl_cnt_q;     // Decel limiting duration
	reg  [9:0]  st_cnt_q;     // Stall duration
	reg  [9:0]  key_cnt_q;    // Since first stop press
	reg         key_arm_q;    // First press seen
	reg  [15:0] inp_cnt_q;
	reg  [15:0] outp_cnt_q;
	reg         retry_q;      // Waiting out retry interval
	reg  [15:0] rwait_q;
	reg  [3:0]  rused_q;
	reg         init_q;       // Cleared after first cycle
	reg         armed_q;      // Run armed; cleared when a fresh run command is required
	reg         run_d1_q;

	wire [1:0]  mode     = ctrl_q[1:0];
	wire        stall_en = ctrl_q[2];
	wire        an_en    = ctrl_q[3];
	wire        pu_guard = ctrl_q[4];
	wire        sw_guard = ctrl_q[5];
	wire        wr       = psel & penable & pwrite;
	wire [15:0] wv       = pwdata[15:0];
	wire [15:0] wv_hi    = pwdata[31:16];
	wire        mapped   = (paddr[1:0] == 2'h0) && (paddr <= `DPS_OFF_FCLR);
	wire [15:0] lim_x10  = lim_lvl_q * 16'h000A;
	wire        ramp     = accel | decel;
	wire        over_pa  = {4'h0, cur_q} > pa_lvl_q;
	wire        lim_hit  = (mode != 2'h0) && ({4'h0, cur_q} >= lim_x10);
	wire        stall    = stall_en & decel & ({5'h00, bus_q} >= stall_q);
	wire        limiting = freq_hold | freq_reduce;
	wire        key_pair = stop_key & key_arm_q & (key_cnt_q >= `DPS_KEY_GAP_DS);
	wire        in_bad   = (inb_q != 16'h0000) &
	                       ({9'h000, in_imbalance} >= inb_q);
	wire        out_bad  = {9'h000, out_imbalance} >= outb_q;
	wire        run_rise = run_cmd & ~run_d1_q;
	wire        blocked  = (fault_flags != 8'h00) | retry_q;
	wire        f_clr    = wr && (paddr == `DPS_OFF_FCLR);
	wire [7:0]  clr_m    = f_clr ? pwdata[7:0] : 8'h00;
	reg  [7:0]  f_set;

	// APB: zero wait, errors on unaligned or unmapped offsets
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Register writes with range clamping
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q   <= `DPS_CTRL_RST;
			pa_lvl_q <= `DPS_PA_LVL_RST;
			pa_tim_q <= `DPS_PA_TIM_RST;
			lim_lvl_q <= HEAVY_DUTY ? `DPS_LIM_HD_RST : `DPS_LIM_LD_RST;
			conf_q   <= `DPS_CONF_RST;
			stall_q  <= V380 ? `DPS_STALL_HI_RST : `DPS_STALL_LO_RST;
			inb_q    <= `DPS_INB_RST;
			int_q    <= `DPS_INT_RST;
			outb_q   <= `DPS_OUTB_RST;
			outt_q   <= `DPS_OUTT_RST;
			rcnt_q   <= `DPS_RCNT_RST;
			rint_q   <= `DPS_RINT_RST;
		end else if (wr) begin
			case (paddr)
				`DPS_OFF_CTRL: ctrl_q <= pwdata[5:0];
				`DPS_OFF_PREALM: begin
					pa_lvl_q <= clampv(wv, `DPS_PA_LVL_MIN,
					                   `DPS_PA_LVL_MAX);
					pa_tim_q <= clampv(wv_hi, 16'h0000,
					                   `DPS_PA_TIM_MAX);
				end
				`DPS_OFF_LIMIT: begin
					lim_lvl_q <= clampv(wv, lim_min, lim_max);
					conf_q <= clampv(wv_hi, 16'h0000, `DPS_CONF_MAX);
				end
				`DPS_OFF_STALL:
					stall_q <= clampv(wv, `DPS_STALL_MIN, `DPS_STALL_MAX);
				`DPS_OFF_PHASE: begin
					inb_q  <= clampv({8'h00, pwdata[7:0]}, 16'h0001,
					                 `DPS_PCT_MAX);
					int_q  <= clampv({8'h00, pwdata[15:8]}, `DPS_INT_MIN,
					                 `DPS_INT_MAX);
					outb_q <= clampv({8'h00, pwdata[23:16]}, 16'h0000,
					                 `DPS_PCT_MAX);
					outt_q <= clampv({8'h00, pwdata[31:24]}, 16'h0000,
					                 `DPS_OUTT_MAX);
				end
				`DPS_OFF_RETRY: begin
					rcnt_q <= clampv(wv, 16'h0000, `DPS_RCNT_MAX);
					rint_q <= clampv(wv_hi, `DPS_RINT_MIN, `DPS_RINT_MAX);
				end
				default: ;
			endcase
		end
	end

	// Read data captured in the setup phase, shown in the access phase
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (psel & ~penable & ~pwrite) begin
			case (paddr)
				`DPS_OFF_CTRL:   prdata <= {26'h0000000, ctrl_q};
				`DPS_OFF_PREALM: prdata <= {pa_tim_q, pa_lvl_q};
				`DPS_OFF_LIMIT:  prdata <= {conf_q, lim_lvl_q};
				`DPS_OFF_STALL:  prdata <= {16'h0000, stall_q};
				`DPS_OFF_PHASE:  prdata <= {outt_q[7:0], outb_q[7:0],
				                            int_q[7:0], inb_q[7:0]};
				`DPS_OFF_RETRY:  prdata <= {rint_q, rcnt_q};
				`DPS_OFF_STATUS: prdata <= {11'h000, rused_q, retry_q,
				                 run_enable, analog_two_alarm,
				                 analog_one_alarm, hw_limit, stall,
				                 freq_reduce, freq_hold,
				                 overload_prealarm_flag, fault_flags};
				default:         prdata <= 32'h00000000;
			endcase
		end
	end

	// Sample latch and 1 ms / 100 ms time base
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_q     <= 12'h000;
			bus_q     <= 11'h000;
			ms_cnt_q  <= 17'h00000;
			ds_cnt_q  <= 7'h00;
			tick_ms_q <= 1'b0;
			tick_ds_q <= 1'b0;
		end else begin
			if (sample_valid) begin
				cur_q <= out_current;
				bus_q <= bus_voltage;
			end
			tick_ms_q <= (ms_cnt_q == ms_last_w[16:0]);
			ms_cnt_q  <= (ms_cnt_q == ms_last_w[16:0]) ? 17'h00000 :
			             ms_cnt_q + 17'h00001;
			tick_ds_q <= tick_ms_q && (ds_cnt_q == `DPS_DS_PER_MS);
			if (tick_ms_q)
				ds_cnt_q <= (ds_cnt_q == `DPS_DS_PER_MS) ? 7'h00 :
				            ds_cnt_q + 7'h01;
		end
	end

	// Persistence timers; each restarts when its condition drops
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pa_cnt_q   <= 16'h0000;
			conf_cnt_q <= 16'h0000;
			dl_cnt_q   <= 10'h000;
			st_cnt_q   <= 10'h000;
			inp_cnt_q  <= 16'h0000;
			outp_cnt_q <= 16'h0000;
			key_cnt_q  <= 10'h000;
			key_arm_q  <= 1'b0;
		end else begin
			if (!over_pa)
				pa_cnt_q <= 16'h0000;
			else if (tick_ds_q && pa_cnt_q < pa_tim_q)
				pa_cnt_q <= pa_cnt_q + 16'h0001;
			if (!(lim_hit && mode == 2'h3))
				conf_cnt_q <= 16'h0000;
			else if (tick_ms_q && conf_cnt_q < conf_q)
				conf_cnt_q <= conf_cnt_q + 16'h0001;
			if (!(decel && limiting))
				dl_cnt_q <= 10'h000;
			else if (tick_ds_q && dl_cnt_q < `DPS_MINUTE_DS)
				dl_cnt_q <= dl_cnt_q + 10'h001;
			if (!stall)
				st_cnt_q <= 10'h000;
			else if (tick_ds_q && st_cnt_q < `DPS_MINUTE_DS)
				st_cnt_q <= st_cnt_q + 10'h001;
			if (!in_bad)
				inp_cnt_q <= 16'h0000;
			else if (tick_ds_q && inp_cnt_q < int_q * 16'h000A)
				inp_cnt_q <= inp_cnt_q + 16'h0001;
			if (!out_bad)
				outp_cnt_q <= 16'h0000;
			else if (tick_ds_q && outp_cnt_q < outt_q)
				outp_cnt_q <= outp_cnt_q + 16'h0001;
			// Stop key pairing only counts while limiting or stalling
			if (!((decel && limiting) || stall)) begin
				key_arm_q <= 1'b0;
				key_cnt_q <= 10'h000;
			end else if (stop_key && !key_pair) begin
				key_arm_q <= 1'b1;
				if (!key_arm_q)
					key_cnt_q <= 10'h000;
			end else if (tick_ds_q && key_cnt_q < `DPS_KEY_GAP_DS) begin
				key_cnt_q <= key_cnt_q + 10'h001;
			end
		end
	end

	// Fault set sources; a set in the clear cycle wins
	always @* begin
		f_set = 8'h00;
		f_set[`DPS_F_MOL]   = thermal_trip;
		f_set[`DPS_F_IOL]   = (dl_cnt_q >= `DPS_MINUTE_DS) |
		                      (key_pair & decel & limiting);
		f_set[`DPS_F_OV]    = (st_cnt_q >= `DPS_MINUTE_DS) |
		                      (key_pair & stall);
		f_set[`DPS_F_OC]    = oc_event;
		f_set[`DPS_F_GF]    = gf_event;
		f_set[`DPS_F_INPH]  = in_bad & (inp_cnt_q >= int_q * 16'h000A);
		f_set[`DPS_F_OUTPH] = out_bad & (outp_cnt_q >= outt_q);
		f_set[`DPS_F_SHORT] = short_event;
	end

	// Faults, automatic retry and output blocking
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_flags   <= 8'h00;
			retry_q       <= 1'b0;
			rwait_q       <= 16'h0000;
			rused_q       <= 4'h0;
			restart_pulse <= 1'b0;
			pwm_block     <= 1'b0;
			coast_stop    <= 1'b0;
		end else begin
			restart_pulse <= 1'b0;
			pwm_block     <= blocked | (f_set != 8'h00);
			coast_stop    <= blocked | (f_set != 8'h00);
			if (retry_q) begin
				// Output held blocked at zero frequency meanwhile
				if (f_set != 8'h00) begin
					fault_flags <= fault_flags | f_set;
					retry_q     <= 1'b0;
				end else if (tick_ds_q && rwait_q + 16'h0001 >= rint_q) begin
					fault_flags   <= fault_flags & ~`DPS_AUTO_MASK;
					retry_q       <= 1'b0;
					restart_pulse <= 1'b1;
				end else if (tick_ds_q) begin
					rwait_q <= rwait_q + 16'h0001;
				end
			end else begin
				fault_flags <= (fault_flags & ~clr_m) | f_set;
				// Only the auto class may retry, and only within count
				if ((f_set != 8'h00) && ((f_set & ~`DPS_AUTO_MASK) == 8'h00)
				    && ((fault_flags & ~`DPS_AUTO_MASK) == 8'h00)
				    && ({12'h000, rused_q} < rcnt_q)) begin
					retry_q <= 1'b1;
					rwait_q <= 16'h0000;
					rused_q <= rused_q + 4'h1;
				end
			end
			if (f_clr)
				rused_q <= 4'h0;
		end
	end

	// Limiting, stall hold, pre-alarm, hardware limit and alarms
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			freq_hold              <= 1'b0;
			freq_reduce            <= 1'b0;
			hw_limit               <= 1'b0;
			overload_prealarm_flag <= 1'b0;
			analog_one_alarm       <= 1'b0;
			analog_two_alarm       <= 1'b0;
		end else begin
			freq_hold <= (lim_hit && ramp && (mode == 2'h1 ||
			             mode == 2'h2)) || stall;
			freq_reduce <= (lim_hit && !ramp && mode == 2'h2) ||
			               (lim_hit && mode == 2'h3 &&
			                conf_cnt_q >= conf_q);
			hw_limit <= (cur_q >= `DPS_HW_LIMIT);
			overload_prealarm_flag <= over_pa &&
			                          (pa_cnt_q >= pa_tim_q);
			analog_one_alarm <= an_en & analog_one_bad;
			analog_two_alarm <= an_en & analog_two_bad;
		end
	end

	// Run permission: power-up guard and command source guard
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_q        <= 1'b1;
			armed_q       <= 1'b0;
			run_d1_q      <= 1'b0;
			run_enable    <= 1'b0;
			decel_to_stop <= 1'b0;
		end else begin
			init_q   <= 1'b0;
			run_d1_q <= run_cmd;
			if (init_q)
				armed_q <= ~(pu_guard & run_cmd);
			else if (source_change && sw_guard)
				armed_q <= 1'b0;
			else if (run_rise)
				armed_q <= 1'b1;
			if (source_change && sw_guard && run_enable)
				decel_to_stop <= 1'b1;
			else if (run_rise || !run_cmd)
				decel_to_stop <= 1'b0;
			run_enable <= ~init_q & run_cmd & ~blocked &
			              (armed_q | run_rise) &
			              ~(source_change & sw_guard);
		end
	end
endmodule

// [dv/dps_checker_assertions.sv]
// Checker for the protection supervisor, bound to its top module.
// Assumes the port list of dps_supervisor and the shared constants.
`timescale 1ns/1ps
`include "dps_consts.vh"
module dps_checker (
	input logic        ref_clk,
	input logic        rst_n,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic        pready,
	input logic        pslverr,
	input logic        sample_valid,
	input logic [11:0] out_current,
	input logic        thermal_trip,
	input logic        analog_one_bad,
	input logic        source_change,
	input logic        pwm_block,
	input logic        coast_stop,
	input logic        hw_limit,
	input logic        analog_one_alarm,
	input logic        analog_two_alarm,
	input logic [7:0]  fault_flags,
	input logic        run_enable
);
	logic [5:0] ctrl_q;  // Shadow of the control register
	logic       fclr_wr; // Fault clear write at its access edge
	assign fclr_wr = psel && penable && pwrite && paddr == `DPS_OFF_FCLR;
	// Follow control writes so enables are known without reading back
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `DPS_CTRL_RST;
		end else if (psel && penable && pwrite && paddr == `DPS_OFF_CTRL) begin
			ctrl_q <= pwdata[5:0];
		end
	end
	default clocking dps_cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Trip latched together with blocked and coasting output
	sequence trip_out_s;
		fault_flags[`DPS_F_MOL] && pwm_block && coast_stop;
	endsequence
	thermal_trip_a: assert property (thermal_trip |=> trip_out_s)
		else $error("thermal trip did not block output");
	hw_limit_on_a: assert property ((sample_valid &&
		out_current >= `DPS_HW_LIMIT) |-> ##[1:3] hw_limit)
		else $error("hardware limit missed");
	hw_limit_off_a: assert property ((sample_valid &&
		out_current < `DPS_HW_LIMIT) |-> ##[1:3] !hw_limit)
		else $error("hardware limit raised below threshold");
	analog_shown_a: assert property ((ctrl_q[3] && analog_one_bad) |=>
		analog_one_alarm) else $error("analog alarm not shown");
	analog_hidden_a: assert property ((!ctrl_q[3] &&
		!$past(ctrl_q[3])) |-> !analog_one_alarm && !analog_two_alarm)
		else $error("analog alarm shown while disabled");
	// Only the three auto classes may drop without a clear write
	manual_faults_a: assert property (!fclr_wr |=>
		((fault_flags & ~`DPS_AUTO_MASK) & $past(fault_flags)) ==
		($past(fault_flags) & ~`DPS_AUTO_MASK))
		else $error("non-auto fault cleared itself");
	fault_blocks_a: assert property ((|fault_flags) |-> pwm_block)
		else $error("fault latched with output running");
	source_guard_a: assert property ((ctrl_q[5] && source_change) |=>
		!run_enable) else $error("run kept after source change");
	apb_ready_a: assert property (psel && penable |-> pready)
		else $error("access phase not answered");
	apb_unmapped_a: assert property ((psel && penable &&
		paddr > `DPS_OFF_FCLR) |-> pslverr) else $error("unmapped accepted");
endmodule
bind dps_supervisor dps_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.sample_valid(sample_valid), .out_current(out_current),
	.thermal_trip(thermal_trip), .analog_one_bad(analog_one_bad),
	.source_change(source_change), .pwm_block(pwm_block),
	.coast_stop(coast_stop), .hw_limit(hw_limit),
	.analog_one_alarm(analog_one_alarm),
	.analog_two_alarm(analog_two_alarm), .fault_flags(fault_flags),
	.run_enable(run_enable));

// [dv/dps_stage_model.sv]
// Power stage sensing model: periodic current and bus voltage samples.
// Assumes the bench sets the levels; one sample every eight cycles.
`timescale 1ns/1ps
module dps_stage_model (
	input  logic        ref_clk,
	input  logic        rst_n,
	input  logic [11:0] cur_set,
	input  logic [10:0] volt_set,
	output logic        sample_valid,
	output logic [11:0] out_current,
	output logic [10:0] bus_voltage
);
	logic [2:0] div_q; // Sample period divider
	// Between samples the data lines carry the inverse, so a design
	// that reads them outside the strobe sees garbage, not old values
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q        <= 3'h0;
			sample_valid <= 1'b0;
			out_current  <= 12'h000;
			bus_voltage  <= 11'h000;
		end else begin
			div_q        <= div_q + 3'h1;
			sample_valid <= (div_q == 3'h7);
			out_current  <= (div_q == 3'h7) ? cur_set : ~cur_set;
			bus_voltage  <= (div_q == 3'h7) ? volt_set : ~volt_set;
		end
	end
endmodule

// [dv/tb.sv]
// Self-checking bench for the protection supervisor over APB.
// Assumes the stage model for sensing and a 10-cycle millisecond.
`timescale 1ns/1ps
`include "dps_consts.vh"
module tb;
	logic        ref_clk = 1'b0, rst_n = 1'b0;  // Clock and reset
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;   // Bus data and read result
	logic        pready, pslverr, err;
	logic        accel = 1'b0, thermal_trip = 1'b0, oc_event = 1'b0;
	logic        an1_bad = 1'b0, an2_bad = 1'b0, run_cmd = 1'b0, src_chg = 1'b0;
	logic [11:0] cur_set = 12'h3E8, out_current; // Current, 0.1 % units
	logic [10:0] bus_voltage, volt_set = 11'h3E8; // Bus voltage, 0.1 %
	logic        sample_valid, pwm_block, coast_stop, freq_hold, freq_reduce;
	logic        hw_limit, prealarm, an1_alm, an2_alm, run_enable, dts;
	logic [7:0]  fault_flags;
	logic        decel = 1'b0, restart;  // Ramp down and retry restart
	int          n_mismatch = 0, n_compared = 0, cycles = 0, i, m;
	// Reset values of the eight words, in address order
	logic [31:0] rst_tab [8] = '{32'h00000005, 32'h02580640, 32'h003200A0,
		32'h00000578, 32'h14010A64, 32'h00320000, 32'h0, 32'h0};
	always #5 ref_clk = ~ref_clk;
	dps_stage_model u_stage (.ref_clk(ref_clk), .rst_n(rst_n),
		.cur_set(cur_set), .volt_set(volt_set), .sample_valid(sample_valid),
		.out_current(out_current), .bus_voltage(bus_voltage));
	// Millisecond shortened to 10 cycles; the timer waits below follow from it
	dps_supervisor #(.MS_CYCLES(10)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_valid(sample_valid), .out_current(out_current),
		.bus_voltage(bus_voltage), .in_imbalance(7'h00),
		.out_imbalance(7'h00), .accel(accel), .decel(decel),
		.thermal_trip(thermal_trip), .oc_event(oc_event), .gf_event(1'b0),
		.short_event(1'b0), .analog_one_bad(an1_bad),
		.analog_two_bad(an2_bad), .stop_key(1'b0), .run_cmd(run_cmd),
		.source_change(src_chg), .pwm_block(pwm_block),
		.coast_stop(coast_stop), .freq_hold(freq_hold),
		.freq_reduce(freq_reduce), .hw_limit(hw_limit),
		.overload_prealarm_flag(prealarm), .analog_one_alarm(an1_alm),
		.analog_two_alarm(an2_alm), .fault_flags(fault_flags),
		.run_enable(run_enable), .decel_to_stop(dts), .restart_pulse(restart));
	// Compare one value, count it, report a mismatch
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; request held until pready is seen high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task give_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Hang guard: the whole sequence needs well under this
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i++) begin
			xfer(1'b0, 8'(i * 4), 32'h0);
			chk("reset word", rst_tab[i], rd);
		end
		xfer(1'b0, 8'h20, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		// Out-of-range settings are clamped to the range ends
		xfer(1'b1, `DPS_OFF_PREALM, 32'h00000010);
		xfer(1'b0, `DPS_OFF_PREALM, 32'h0);
		chk("prealarm clamp", 32'h000000C8, rd);
		xfer(1'b1, `DPS_OFF_LIMIT, 32'h003200FF);
		xfer(1'b0, `DPS_OFF_LIMIT, 32'h0);
		chk("limit clamp", 32'h003200B4, rd);
		xfer(1'b1, `DPS_OFF_LIMIT, 32'h003200A0);
		$display("test registers done");
		// Every limit mode, on a ramp and then at constant speed
		for (m = 0; m < 4; m++) begin
			xfer(1'b1, `DPS_OFF_CTRL, 32'h4 | 32'(m));
			accel <= 1'b1;
			cur_set <= 12'h6A4;
			repeat (16) @(posedge ref_clk);
			if (m < 3) chk("ramp hold", 32'(m == 1 || m == 2), {31'h0, freq_hold});
			chk("early reduce", 32'h0, {31'h0, freq_reduce});
			if (m == 3) repeat (600) @(posedge ref_clk);
			accel <= 1'b0;
			repeat (16) @(posedge ref_clk);
			chk("const reduce", 32'(m >= 2), {31'h0, freq_reduce});
			cur_set <= 12'h3E8;
			repeat (16) @(posedge ref_clk);
			chk("reduce released", 32'h0, {31'h0, freq_reduce});
		end
		xfer(1'b1, `DPS_OFF_CTRL, 32'h05);
		cur_set <= 12'h8FC;
		repeat (16) @(posedge ref_clk);
		chk("hw limit at edge", 32'h1, {31'h0, hw_limit});
		cur_set <= 12'h8FB;
		repeat (16) @(posedge ref_clk);
		chk("hw limit below", 32'h0, {31'h0, hw_limit});
		cur_set <= 12'h3E8;
		// Bus above the stall point while ramping down holds frequency
		decel <= 1'b1;
		volt_set <= 11'h5DC;
		repeat (16) @(posedge ref_clk);
		chk("stall hold", 32'h1, {31'h0, freq_hold});
		decel <= 1'b0;
		volt_set <= 11'h3E8;
		$display("test limiting done");
		xfer(1'b1, `DPS_OFF_CTRL, 32'h0D);
		an1_bad <= 1'b1;
		an2_bad <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("analog shown", 32'h3, {30'h0, an2_alm, an1_alm});
		xfer(1'b1, `DPS_OFF_CTRL, 32'h25);
		repeat (4) @(posedge ref_clk);
		chk("analog hidden", 32'h0, {30'h0, an2_alm, an1_alm});
		an1_bad <= 1'b0;
		an2_bad <= 1'b0;
		// Source change while running needs a fresh run edge
		run_cmd <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("run", 32'h1, {31'h0, run_enable});
		src_chg <= 1'b1;
		@(posedge ref_clk);
		src_chg <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("switch stop", 32'h1, {30'h0, run_enable, dts});
		run_cmd <= 1'b0;
		repeat (4) @(posedge ref_clk);
		run_cmd <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("rerun", 32'h2, {30'h0, run_enable, dts});
		run_cmd <= 1'b0;
		$display("test commands done");
		thermal_trip <= 1'b1;
		oc_event <= 1'b1;
		@(posedge ref_clk);
		thermal_trip <= 1'b0;
		oc_event <= 1'b0;
		repeat (300) @(posedge ref_clk);
		chk("faults kept", 32'h109, {23'h0, pwm_block, fault_flags});
		xfer(1'b1, `DPS_OFF_FCLR, 32'h09);
		repeat (4) @(posedge ref_clk);
		chk("faults cleared", 32'h0, {23'h0, pwm_block, fault_flags});
		// One retry of 2.0 s: output blocked, then the fault goes
		xfer(1'b1, `DPS_OFF_RETRY, 32'h00140001);
		oc_event <= 1'b1;
		@(posedge ref_clk);
		oc_event <= 1'b0;
		repeat (10000) @(posedge ref_clk);
		chk("retry blocked", 32'h1, {31'h0, pwm_block});
		for (i = 0; i < 14000 && fault_flags !== 8'h00; i++) @(posedge ref_clk);
		chk("restart pulse", 32'h1, {31'h0, restart});
		repeat (4) @(posedge ref_clk);
		chk("retry done", 32'h0, {23'h0, pwm_block, fault_flags});
		$display("test faults done");
		// Pre-alarm: 0.3 s at 100.0 %, checked early at 0.15 s and awaited up to 0.55 s
		xfer(1'b1, `DPS_OFF_PREALM, 32'h000303E8);
		cur_set <= 12'h44C;
		repeat (1500) @(posedge ref_clk);
		chk("prealarm early", 32'h0, {31'h0, prealarm});
		cur_set <= 12'h384;
		repeat (20) @(posedge ref_clk);
		cur_set <= 12'h44C;
		repeat (1500) @(posedge ref_clk);
		chk("prealarm restart", 32'h0, {31'h0, prealarm});
		for (i = 0; i < 4000 && prealarm !== 1'b1; i++) @(posedge ref_clk);
		chk("prealarm", 32'h1, {31'h0, prealarm});
		$display("test prealarm done");
		give_verdict();
	end
endmodule
